// ---- verilog/tag_ram_pkg.sv ----
// constants for the pipelined tag compare ram
// assumes one 100 MHz system clock
package tag_ram_pkg;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 8;
  localparam int BURST_W = 2;
  localparam int HALF_W = 9;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 18'h00000;
endpackage : tag_ram_pkg

// ---- verilog/burst_seq.sv ----
// burst address sequencer for the two low address bits
// assumes load and advance come from logic on sys_clk
`timescale 1ns/1ps
module burst_seq (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic advance,
  input wire logic interleaved,
  input wire logic [tag_ram_pkg::BURST_W-1:0] start,
  output logic [tag_ram_pkg::BURST_W-1:0] low_addr
);
  import tag_ram_pkg::*;
  logic [BURST_W-1:0] base;
  logic [BURST_W-1:0] step;
  logic [BURST_W-1:0] next_base;
  logic [BURST_W-1:0] next_step;

  always_comb begin
    next_base = base;
    next_step = step;
    if (load) begin
      next_base = start;
      next_step = BURST_ZERO;
    end else if (advance) begin
      next_step = step + BURST_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      base <= BURST_ZERO;
      step <= BURST_ZERO;
    end else begin
      base <= next_base;
      step <= next_step;
    end
  end

  assign low_addr = interleaved ? (base ^ step) : (base + step);
endmodule : burst_seq

// ---- verilog/tag_compare_ram.sv ----
// pipelined tag compare ram: array, burst sequencer, comparator, hit pipeline
// assumes all synchronous pins are already on sys_clk; the two output enables are async
//
// Notes on behaviour
// - hit output driven only while hit_out_enable_n low, asynchronously.
// - shared 18-bit data bus sampled at rising clock edge.
// - burst order select high: interleaved, start xor 01, 10, 11.
// - burst order select low: linear count up, wrapping 11 to 00.
// - selected only when both low enables low and high enable high.
// - write qualifier is (gate or (low and high)) and all-bytes write.
// - compare cycle latches tag from bus and shows hit result.
// - write takes bus data; fill write keeps bus floating.
// - deselected: bus floats, hit high if enabled else floating.
// - every input sampled at clock edge except the two output enables and the async reset rst_n.
// - all outputs float during power-up until operation begins.
// - compare registers load only when compare latch enable asserted.
// - while selected, hit high when compare registers equal addressed word, else low.
`timescale 1ns/1ps
module tag_compare_ram #(
  parameter int ADDR_BITS = tag_ram_pkg::ADDR_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_BITS-1:0] addr,
  input wire logic chip_sel_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_hi,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_adv_n,
  input wire logic burst_order,
  input wire logic byte_write_gate_n,
  input wire logic low_byte_write_n,
  input wire logic high_byte_write_n,
  input wire logic all_bytes_write_n,
  input wire logic compare_latch_en_n,
  input wire logic data_out_enable_n,
  input wire logic hit_out_enable_n,
  input wire logic [tag_ram_pkg::DATA_W-1:0] data_in,
  output logic [tag_ram_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic hit_out,
  output logic hit_oe
);
  import tag_ram_pkg::*;

  // refused at elaboration: the burst bits must leave at least one upper address bit
  if (ADDR_BITS <= BURST_W) begin : g_bad_addr
    $error("address too narrow for burst bits");
  end

  localparam int DEPTH = 1 << ADDR_BITS;
  logic [DATA_W-1:0] mem [DEPTH];

  logic selected;
  logic write_q_n;
  logic strobe;
  logic [ADDR_BITS-1:0] addr_hi;
  logic [ADDR_BITS-1:0] next_addr_hi;
  logic [BURST_W-1:0] low_addr;
  logic [ADDR_BITS-1:0] cur_addr;
  logic [DATA_W-1:0] cmp_reg;
  logic [DATA_W-1:0] next_cmp_reg;
  logic [DATA_W-1:0] next_data_out;
  logic next_hit;
  logic hit_reg;
  logic sel_reg;
  logic next_sel;
  logic read_reg;
  logic next_read;
  logic running;
  logic do_write;
  logic [1:0] lane_we;

  assign selected = !chip_sel_n && !chip_sel_b && chip_sel_hi;
  assign write_q_n = (byte_write_gate_n | (low_byte_write_n & high_byte_write_n))
                     & all_bytes_write_n;
  assign strobe = (!proc_addr_strobe_n && !chip_sel_n) || !ctrl_addr_strobe_n;
  assign cur_addr = {addr_hi[ADDR_BITS-1:BURST_W], low_addr};

  burst_seq u_seq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(strobe && selected),
    .advance(!strobe && !burst_adv_n),
    .interleaved(burst_order),
    .start(addr[BURST_W-1:0]),
    .low_addr(low_addr)
  );

  // byte lanes: global write takes both, else gate plus per-lane enable
  assign lane_we[0] = !all_bytes_write_n || (!byte_write_gate_n && !low_byte_write_n);
  assign lane_we[1] = !all_bytes_write_n || (!byte_write_gate_n && !high_byte_write_n);
  // write proceeds with or without bus data
  assign do_write = running && !write_q_n && (strobe ? proc_addr_strobe_n : 1'b1);

  always_comb begin
    next_addr_hi = addr_hi;
    next_sel = sel_reg;
    next_read = 1'b0;
    next_cmp_reg = cmp_reg;
    if (!proc_addr_strobe_n && chip_sel_n && ctrl_addr_strobe_n) begin
      next_sel = sel_reg;
    end else if (strobe) begin
      next_sel = selected;
      if (selected) next_addr_hi = addr;
    end
    // latch only on enable while selected
    if (!compare_latch_en_n && selected) next_cmp_reg = data_in;
    next_read = next_sel && write_q_n;
    next_data_out = mem[cur_addr];
    if (strobe && selected) next_data_out = mem[addr];
    next_hit = (next_cmp_reg == mem[strobe ? addr : cur_addr]);
    if (!next_sel) next_hit = 1'b1;
  end
  assign running = sel_reg || (strobe && selected);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_hi <= '0;
      sel_reg <= 1'b0;
      read_reg <= 1'b0;
      cmp_reg <= DATA_ZERO;
      data_out <= DATA_ZERO;
      hit_reg <= 1'b1;
    end else begin
      addr_hi <= next_addr_hi;
      sel_reg <= next_sel;
      read_reg <= next_read;
      cmp_reg <= next_cmp_reg;
      data_out <= next_data_out;
      hit_reg <= next_hit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (do_write && !compare_latch_en_n) begin
      if (lane_we[0]) mem[strobe ? addr : cur_addr][HALF_W-1:0] <= data_in[HALF_W-1:0];
      if (lane_we[1]) mem[strobe ? addr : cur_addr][DATA_W-1:HALF_W] <= data_in[DATA_W-1:HALF_W];
    end else if (do_write) begin
      // fill write: word comes from the compare registers, bus stays floating
      if (lane_we[0]) mem[strobe ? addr : cur_addr][HALF_W-1:0] <= cmp_reg[HALF_W-1:0];
      if (lane_we[1]) mem[strobe ? addr : cur_addr][DATA_W-1:HALF_W] <= cmp_reg[DATA_W-1:HALF_W];
    end
  end

  // bus driven only for a selected read, async enable
  assign data_oe = rst_n && read_reg && !data_out_enable_n;
  assign hit_oe = rst_n && !hit_out_enable_n;
  assign hit_out = hit_reg;

  // checks sit at the clock edge; the async enables are seen only as sampled there
  a_bus_quiet_reset: assert property (
    @(posedge sys_clk) !rst_n |-> !data_oe && !hit_oe)
    else $error("outputs driven in reset");
  a_hit_enable: assert property (
    @(posedge sys_clk) disable iff (!rst_n) hit_oe == !hit_out_enable_n)
    else $error("hit enable mismatch");
  a_desel_hit_high: assert property (
    @(posedge sys_clk) disable iff (!rst_n) (strobe && !selected) |=> hit_out)
    else $error("hit low while deselected");
  a_desel_bus_float: assert property (
    @(posedge sys_clk) disable iff (!rst_n) (strobe && !selected) |=> !data_oe)
    else $error("bus driven while deselected");
  a_latch_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n) compare_latch_en_n |=> $stable(cmp_reg))
    else $error("compare register moved");
  a_latch_load: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!compare_latch_en_n && selected) |=> cmp_reg == $past(data_in))
    else $error("compare register not loaded");
  a_write_no_drive: assert property (
    @(posedge sys_clk) disable iff (!rst_n) (running && !write_q_n) |=> !data_oe)
    else $error("bus driven in write");
  a_read_drive: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (strobe && selected && write_q_n && !data_out_enable_n) |=> ##0
    (data_oe || data_out_enable_n))
    else $error("read not driven");
  a_write_qual: assert property (
    @(posedge sys_clk) disable iff (!rst_n) !all_bytes_write_n |-> !write_q_n)
    else $error("global write not a write");
  a_oe_gate: assert property (
    @(posedge sys_clk) disable iff (!rst_n) data_out_enable_n |-> !data_oe)
    else $error("bus driven with output enable high");
  a_hit_match: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (strobe && selected && write_q_n && !compare_latch_en_n && data_in == mem[addr])
    |=> hit_out)
    else $error("tag match not reported");
  a_hit_miss: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (strobe && selected && write_q_n && !compare_latch_en_n && data_in != mem[addr])
    |=> !hit_out)
    else $error("tag miss not reported");
  a_sel_decode: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (strobe && (chip_sel_n || chip_sel_b || !chip_sel_hi)) |=> !sel_reg)
    else $error("selected with an enable inactive");
  a_fill_float: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (running && !write_q_n && compare_latch_en_n) |=> !data_oe)
    else $error("bus driven in fill write");
  a_linear_step: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!strobe && !burst_adv_n && !burst_order && sel_reg)
    |=> low_addr == $past(low_addr) + BURST_ONE)
    else $error("linear burst step wrong");

  c_compare: cover property (@(posedge sys_clk) disable iff (!rst_n)
    strobe && selected && write_q_n && !compare_latch_en_n ##1 hit_oe && hit_out);
  c_read: cover property (@(posedge sys_clk) disable iff (!rst_n) data_oe);
  c_miss: cover property (@(posedge sys_clk) disable iff (!rst_n) hit_oe && !hit_out);
  c_fill: cover property (@(posedge sys_clk) disable iff (!rst_n)
    running && !write_q_n && compare_latch_en_n);
  c_desel: cover property (@(posedge sys_clk) disable iff (!rst_n)
    strobe && !selected ##1 hit_oe && hit_out);
endmodule : tag_compare_ram

// ---- sim/ctrl_bus.sv ----
// controller side of the shared tag data bus
// assumes drive and wdata change just after the rising edge of sys_clk
`timescale 1ns/1ps
module ctrl_bus (
  input wire logic sys_clk,
  input wire logic drive,
  input wire logic data_out_enable_n,
  input wire logic [tag_ram_pkg::DATA_W-1:0] wdata,
  input wire logic [tag_ram_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  output logic [tag_ram_pkg::DATA_W-1:0] data_in
);
  logic [tag_ram_pkg::DATA_W-1:0] last = '0;
  // drive only with device output disabled, held a cycle
  // an idle bus shows the inverse of the last level, never a stale value
  always_comb begin
    if (data_oe) data_in = data_out;
    else if (drive && data_out_enable_n) data_in = wdata;
    else data_in = ~last;
  end
  always_ff @(posedge sys_clk) last <= data_in;
endmodule : ctrl_bus

// ---- sim/tb.sv ----
// self-checking bench for the tag compare ram
// assumes the controller bus model in ctrl_bus
`timescale 1ns/1ps
module tb;
  import tag_ram_pkg::*;
  logic sys_clk = 0, rst_n = 0, ce_n = 0, ce_b = 0, ce_hi = 1, pas_n = 1, cas_n = 1, adv_n = 1;
  logic order = 1, gate_n = 1, low_n = 1, high_n = 1, all_n = 1, den_n = 1, oe_n = 1;
  logic moe_n = 1, drive = 0, data_oe, hit_out, hit_oe;
  logic [ADDR_W-1:0] addr = '0, base;
  logic [DATA_W-1:0] wdata = '0, data_in, data_out, mem[4];
  logic [1:0] s;
  int err_count = 0, n_tests = 0, seed = 43929;
  always #5 sys_clk = ~sys_clk;
  tag_compare_ram i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .chip_sel_n(ce_n),
    .chip_sel_b(ce_b), .chip_sel_hi(ce_hi), .proc_addr_strobe_n(pas_n),
    .ctrl_addr_strobe_n(cas_n), .burst_adv_n(adv_n), .burst_order(order),
    .byte_write_gate_n(gate_n), .low_byte_write_n(low_n), .high_byte_write_n(high_n),
    .all_bytes_write_n(all_n), .compare_latch_en_n(den_n), .data_out_enable_n(oe_n),
    .hit_out_enable_n(moe_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .hit_out(hit_out), .hit_oe(hit_oe));
  ctrl_bus i_ctrl (.sys_clk(sys_clk), .drive(drive), .data_out_enable_n(oe_n), .wdata(wdata),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic idle;
    {pas_n, cas_n, gate_n, low_n, high_n, all_n, den_n} = '1;
    drive = 0;
  endtask : idle
  function automatic logic [1:0] seq(input logic [1:0] st, input logic [1:0] k, input logic ord);
    return ord ? st ^ k : st + k;
  endfunction : seq
  task automatic print_verdict;
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    chk("data_oe in reset", 0, 18'(data_oe));
    chk("hit_oe in reset", 0, 18'(hit_oe));
    rst_n = 1;
    tick;
    base = ADDR_W'($random(seed)) & 8'hfc;
    for (int i = 0; i < 4; i++) begin
      mem[i] = DATA_W'($random(seed));
      addr = base + ADDR_W'(i); cas_n = 0; den_n = 0; drive = 1; wdata = mem[i];
      if (i % 2 == 1) {gate_n, low_n, high_n} = '0; else all_n = 0;
      tick; idle; tick;
    end
    // gate high with both byte enables low must stay a read
    addr = base; cas_n = 0; low_n = 0; high_n = 0; drive = 1; wdata = ~mem[0]; tick; idle; tick;
    for (int m = 0; m < 4; m++) begin
      order = m[0]; s = 2'($random(seed)); addr = base | ADDR_W'(s); cas_n = 0; oe_n = 0;
      for (int k = 0; k < 5; k++) begin
        tick; idle; adv_n = (k >= 3);
        if (k > 0) chk("burst word", mem[seq(s, 2'(k - 1), order)], data_out);
        if (k > 0) chk("read drive", 1, 18'(data_oe));
      end
      oe_n = 1;
      tick;
    end
    moe_n = 0;
    for (int j = 0; j < 8; j++) begin
      addr = base + ADDR_W'(j % 4); cas_n = 0; den_n = 0; drive = 1;
      wdata = mem[j % 4] ^ DATA_W'(j / 4);
      tick; idle; tick;
      chk("hit", 18'(j < 4), 18'(hit_out));
      chk("hit drive", 1, 18'(hit_oe));
      addr = base + ADDR_W'(j % 4); cas_n = 0; drive = 1; wdata = ~wdata;
      tick; idle; tick;
      chk("hit held", 18'(j < 4), 18'(hit_out));
    end
    // fill write stores the latched tag, which is still mem[3] with bit 0 flipped
    mem[3] = mem[3] ^ DATA_W'(1);
    addr = base + ADDR_W'(3); cas_n = 0; all_n = 0; tick;
    chk("fill bus", 0, 18'(data_oe));
    idle; tick;
    cas_n = 0; oe_n = 0; tick; idle; tick;
    chk("fill word", mem[3], data_out);
    oe_n = 0;
    for (int d = 0; d < 3; d++) begin
      {ce_n, ce_b, ce_hi} = 3'h1 ^ (3'h4 >> d); cas_n = 0;
      tick; idle; tick;
      chk("deselect bus", 0, 18'(data_oe));
      chk("deselect hit", 1, 18'(hit_out));
      {ce_n, ce_b, ce_hi} = 3'h1;
    end
    moe_n = 1;
    #1 chk("hit float", 0, 18'(hit_oe));
    print_verdict();
  end
endmodule : tb
